// File: inc/ncfg_pkg.sv
// Shared constants and types for the contactless configuration block
`default_nettype none
package ncfg_pkg;
    // ====================================================================
    // Page map (one page is one 4-byte word)
    localparam int PAGE_AW = 7;
    localparam logic [6:0] IDENT_LO = 7'h00;
    localparam logic [6:0] IDENT_HI = 7'h17;
    localparam logic [6:0] FREE_LO = 7'h18;
    localparam logic [6:0] FREE_HI = 7'h27;
    localparam logic [6:0] HDR_LO = 7'h28;
    localparam logic [6:0] HDR_HI = 7'h2B;
    localparam logic [6:0] HDR_START = 7'h29;
    localparam logic [6:0] LIVE_LO = 7'h2C;
    localparam logic [6:0] LIVE_HI = 7'h4F;
    localparam logic [6:0] STAGE_LO = 7'h50;
    localparam logic [6:0] STAGE_HI = 7'h7B;
    localparam int LIVE_N = 36;
    localparam int STAGE_N = 44;
    localparam int FREE_N = 16;
    // Live-area indices of the pages the block answers itself
    localparam logic [5:0] PMASK_IDX = 6'h19;
    localparam logic [5:0] RMASK_IDX = 6'h1A;
    localparam logic [5:0] STATUS_IDX = 6'h21;
    // ====================================================================
    // Option bitmap
    localparam int OPT_N = 18;
    localparam int OPT_PAIR = 18;
    localparam int OPT_FRESET = 19;
    localparam logic [31:0] OPT_IMPL = 32'h000F_FFFF;
    // ====================================================================
    // Values after reset
    localparam logic [31:0] LIVE_RST = 32'h0000_0000;
    localparam logic [31:0] PPIN_RST = 32'hE535_0002;
    localparam logic [31:0] RPIN_RST = 32'hE535_0003;
    localparam logic [31:0] KEY_SEED = 32'hACE1_1234;
    localparam int MESH_BIT = 8;
    // Layout descriptor bytes
    localparam logic [7:0] HDR_START_B = 8'hE0;
    localparam logic [7:0] HDR_LEN_B = 8'h0A;
    localparam logic [7:0] HDR_VER_B = 8'h01;
    // ====================================================================
    // Types
    typedef enum logic [2:0] {
        NCFG_REQ_UPDATE, NCFG_REQ_PAIR, NCFG_REQ_UNPAIR, NCFG_REQ_FRESET, NCFG_REQ_SETMASK
    } ncfg_req_e;
    typedef enum logic [1:0] {
        NCFG_OK, NCFG_DENIED, NCFG_BADARG, NCFG_BADPIN
    } ncfg_resp_e;
    typedef enum logic [1:0] {
        NCFG_MSG_DATA, NCFG_MSG_PAIR, NCFG_MSG_UNPAIR
    } ncfg_msg_e;
endpackage
`default_nettype wire

// File: inc/ncfg_chk_if.sv
// Signals between the request handler and the credential checker
`default_nettype none
interface ncfg_chk_if;
    logic user; // 1 = restricted user
    logic [31:0] pin; // Supplied PIN
    logic [31:0] need; // Option bits the request touches
    logic [31:0] ppin;
    logic [31:0] rpin;
    logic [31:0] pmask;
    logic [31:0] rmask;
    logic pin_ok;
    logic perm_ok;
    modport req (output user, pin, need, ppin, rpin, pmask, rmask, input pin_ok, perm_ok);
    modport chk (input user, pin, need, ppin, rpin, pmask, rmask, output pin_ok, perm_ok);
endinterface
`default_nettype wire

// File: verilog/ncfg_chk.sv
// Credential and permission checker for configuration requests
`default_nettype none
module ncfg_chk (
    ncfg_chk_if.chk c
);
    // ====================================================================
    // Checks
    logic [31:0] mask; // Bitmap of the requesting user

    // Pick the bitmap of whoever asks
    always_comb begin
        mask = c.user ? c.rmask : c.pmask;
    end

    // Each user proves itself with its own PIN only
    assign c.pin_ok = c.user ? (c.pin == c.rpin) : (c.pin == c.ppin);
    // Every touched option must be granted, all or nothing
    assign c.perm_ok = ((c.need & ~mask) == 32'h0000_0000);
endmodule
`default_nettype wire

// File: verilog/ncfg_top.sv
// Contactless configuration store with two-user request handling
`default_nettype none
// How it works
// - Behaviour follows only the live settings area.
// - Staging copies act only after an update.
// - Bitmap: 32 positions, 18 settings, 2 actions.
// - Change or action needs the user's bit set.
// - Cleared restricted bit gives access-denied answer.
// - Unimplemented bitmap positions read as zero.
// - Teach button at actuation sends pairing message.
// - Accepted pairing: pairing message on next actuation.
// - Mesh radio: unpairing message on next actuation.
// - Low-energy radio: unpairing refused, bad argument.
// - Factory reset restores defaults, renews link key.
// - Restricted reset touches only its permitted settings.
// - Memory addressed in four-byte pages.
// - Pages 0x00-0x17 identity text, read only.
// - Pages 0x18-0x27 free text, read and write.
// - Pages 0x28-0x2B read-only layout descriptor.
// - Pages 0x2C-0x4F live settings, read only.
// - Pages 0x50-0x7B staging, write only, PIN applies; page writes here take no PIN.
// - Identity text holds source address, 12 hex.
// - Identity text points to descriptor page 0x29.
// - Every request checked against user's own PIN.
// - Update copies only the selected registers.
// - Only privileged user changes restricted bitmap.
module ncfg_top #(
    parameter logic [47:0] SRC_ADDR = 48'h0000_0000_0000,
    parameter logic [31:0] FW_VER = 32'h0100_0000,
    parameter logic [15:0] OEM_CODE = 16'h0000 // Arbitrary maker code
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [6:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output var logic [31:0] rdata_o,
    input wire logic req_i,
    input wire logic req_user_i,
    input wire ncfg_pkg::ncfg_req_e req_kind_i,
    input wire logic [31:0] req_pin_i,
    input wire logic [31:0] req_sel_i,
    output var logic resp_valid_o,
    output var ncfg_pkg::ncfg_resp_e resp_code_o,
    input wire logic teach_btn_i,
    input wire logic harv_press_i,
    input wire logic harv_release_i,
    output var logic msg_valid_o,
    output var ncfg_pkg::ncfg_msg_e msg_kind_o,
    output var logic [31:0] link_key_o,
    output var logic [31:0] live_cfg_o
);
    // ====================================================================
    // Storage
    logic [31:0] live_mem [ncfg_pkg::LIVE_N]; // Settings the device runs on
    logic [31:0] stage_mem [ncfg_pkg::STAGE_N]; // Shadow copies, never acted on
    logic [31:0] free_mem [ncfg_pkg::FREE_N]; // Free user text
    logic [31:0] pmask_reg; // Privileged bitmap, fixed
    logic [31:0] rmask_reg; // Restricted bitmap
    logic [31:0] ppin_reg;
    logic [31:0] rpin_reg;
    logic [31:0] lfsr_reg; // Free-running random source
    logic [31:0] key_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic resp_valid_reg;
    ncfg_pkg::ncfg_resp_e resp_code_reg;
    ncfg_pkg::ncfg_resp_e code_next;
    logic pair_pend_reg;
    logic unpair_pend_reg;
    logic msg_valid_reg;
    ncfg_pkg::ncfg_msg_e msg_kind_reg;
    logic [2:0] sync1_reg; // First stage, read only by the second
    logic [2:0] sync2_reg;
    logic [1:0] prev_reg; // Last synced press and release levels
    logic act; // One harvester movement
    logic mesh; // Mesh radio selected in live settings
    logic accept;
    logic [31:0] umask; // Bitmap of the requester
    ncfg_chk_if chk_bus ();

    // ====================================================================
    // Helper functions
    function automatic logic [7:0] hexc(input logic [3:0] n);
        hexc = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction

    // Byte i of the identity text
    function automatic logic [7:0] ident_byte(input logic [6:0] i);
        logic [71:0] mid;
        int k;
        mid = "+3C29+16S";
        k = 0;
        ident_byte = 8'h00;
        if (i < 7'h03) begin
            k = int'(i);
            ident_byte = (k == 2) ? 8'h53 : ((k == 1) ? 8'h30 : 8'h33);
        end else if (i < 7'h0F) begin
            k = int'(i) - 3;
            ident_byte = hexc(SRC_ADDR[47 - 4 * k -: 4]);
        end else if (i < 7'h18) begin
            k = int'(i) - 15;
            ident_byte = mid[71 - 8 * k -: 8];
        end else if (i < 7'h20) begin
            k = int'(i) - 24;
            ident_byte = hexc(FW_VER[31 - 4 * k -: 4]);
        end
    endfunction

    // Option bits that a request touches
    function automatic logic [31:0] req_need(input ncfg_pkg::ncfg_req_e kind,
                                             input logic [31:0] sel);
        unique case (kind)
            ncfg_pkg::NCFG_REQ_UPDATE: req_need = sel;
            ncfg_pkg::NCFG_REQ_PAIR,
            ncfg_pkg::NCFG_REQ_UNPAIR: req_need = 32'h1 << ncfg_pkg::OPT_PAIR;
            ncfg_pkg::NCFG_REQ_FRESET: req_need = 32'h1 << ncfg_pkg::OPT_FRESET;
            default: req_need = 32'h0000_0000;
        endcase
    endfunction

    // ====================================================================
    // Request checking
    assign chk_bus.user = req_user_i;
    assign chk_bus.pin = req_pin_i;
    assign chk_bus.need = req_need(req_kind_i, req_sel_i);
    assign chk_bus.ppin = ppin_reg;
    assign chk_bus.rpin = rpin_reg;
    assign chk_bus.pmask = pmask_reg;
    assign chk_bus.rmask = rmask_reg;

    ncfg_chk u_chk (
        .c(chk_bus)
    );

    // Radio choice read straight from the live copy
    assign mesh = live_mem[0][ncfg_pkg::MESH_BIT];
    assign umask = req_user_i ? rmask_reg : pmask_reg;

    // Answer priority: PIN, then permission, then argument
    always_comb begin
        if (!chk_bus.pin_ok) begin
            code_next = ncfg_pkg::NCFG_BADPIN;
        end else if (req_kind_i == ncfg_pkg::NCFG_REQ_SETMASK && req_user_i) begin
            code_next = ncfg_pkg::NCFG_DENIED;
        end else if (!chk_bus.perm_ok) begin
            code_next = ncfg_pkg::NCFG_DENIED;
        end else if (req_kind_i == ncfg_pkg::NCFG_REQ_UNPAIR && !mesh) begin
            code_next = ncfg_pkg::NCFG_BADARG;
        end else begin
            code_next = ncfg_pkg::NCFG_OK;
        end
    end

    // Nothing changes unless every check passed
    assign accept = req_i && (code_next == ncfg_pkg::NCFG_OK);

    // Answer one cycle after the request
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            resp_valid_reg <= 1'b0;
            resp_code_reg <= ncfg_pkg::NCFG_OK;
        end else begin
            resp_valid_reg <= req_i;
            if (req_i) begin
                resp_code_reg <= code_next;
            end
        end
    end

    // ====================================================================
    // Live settings
    // A restricted reset only touches what that user may change
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < ncfg_pkg::LIVE_N; i++) begin
                live_mem[i] <= ncfg_pkg::LIVE_RST;
            end
        end else if (accept) begin
            for (int i = 0; i < ncfg_pkg::OPT_N; i++) begin
                if (req_kind_i == ncfg_pkg::NCFG_REQ_UPDATE && req_sel_i[i]) begin
                    live_mem[i] <= stage_mem[i];
                end else if (req_kind_i == ncfg_pkg::NCFG_REQ_FRESET && umask[i]) begin
                    live_mem[i] <= ncfg_pkg::LIVE_RST;
                end
            end
        end
    end

    // Bitmaps: reserved positions are forced to zero
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pmask_reg <= ncfg_pkg::OPT_IMPL;
            rmask_reg <= ncfg_pkg::OPT_IMPL;
            ppin_reg <= ncfg_pkg::PPIN_RST;
            rpin_reg <= ncfg_pkg::RPIN_RST;
        end else if (accept && req_kind_i == ncfg_pkg::NCFG_REQ_SETMASK) begin
            rmask_reg <= req_sel_i & ncfg_pkg::OPT_IMPL;
        end
    end

    // Link key renewed from the random source on factory reset
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            lfsr_reg <= ncfg_pkg::KEY_SEED;
            key_reg <= ncfg_pkg::KEY_SEED;
        end else begin
            lfsr_reg <= {lfsr_reg[30:0],
                         lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
            if (accept && req_kind_i == ncfg_pkg::NCFG_REQ_FRESET) begin
                key_reg <= lfsr_reg;
            end
        end
    end

    // ====================================================================
    // Page bus writes
    // Staging and free text take writes; other areas ignore them
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < ncfg_pkg::STAGE_N; i++) begin
                stage_mem[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < ncfg_pkg::FREE_N; i++) begin
                free_mem[i] <= 32'h0000_0000;
            end
        end else if (wr_i) begin
            if (addr_i >= ncfg_pkg::STAGE_LO && addr_i <= ncfg_pkg::STAGE_HI) begin
                stage_mem[6'(addr_i - ncfg_pkg::STAGE_LO)] <= wdata_i;
            end else if (addr_i >= ncfg_pkg::FREE_LO && addr_i <= ncfg_pkg::FREE_HI) begin
                free_mem[4'(addr_i - ncfg_pkg::FREE_LO)] <= wdata_i;
            end
        end
    end

    // ====================================================================
    // Page bus reads
    // Byte 0 of a page sits in bits 7:0
    always_comb begin
        logic [5:0] li;
        li = 6'(addr_i - ncfg_pkg::LIVE_LO);
        rdata_next = 32'h0000_0000;
        if (addr_i <= ncfg_pkg::IDENT_HI) begin
            for (int b = 0; b < 4; b++) begin
                rdata_next[8 * b +: 8] = ident_byte(7'({addr_i, 2'b00} + b));
            end
        end else if (addr_i <= ncfg_pkg::FREE_HI) begin
            rdata_next = free_mem[4'(addr_i - ncfg_pkg::FREE_LO)];
        end else if (addr_i <= ncfg_pkg::HDR_HI) begin
            if (addr_i == ncfg_pkg::HDR_START) begin
                rdata_next = {OEM_CODE[15:8], ncfg_pkg::HDR_VER_B,
                              ncfg_pkg::HDR_LEN_B, ncfg_pkg::HDR_START_B};
            end
        end else if (addr_i <= ncfg_pkg::LIVE_HI) begin
            if (li == ncfg_pkg::PMASK_IDX) begin
                rdata_next = pmask_reg;
            end else if (li == ncfg_pkg::RMASK_IDX) begin
                rdata_next = rmask_reg;
            end else if (li == ncfg_pkg::STATUS_IDX) begin
                rdata_next = {28'h0, unpair_pend_reg, pair_pend_reg, resp_code_reg};
            end else begin
                rdata_next = live_mem[li];
            end
        end
        // Staging and unmapped pages read as zero
    end

    // Read data stand only in the cycle after the strobe
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0000_0000;
        end else begin
            rdata_reg <= rd_i ? rdata_next : 32'h0000_0000;
        end
    end

    // ====================================================================
    // Harvester and teach button
    // Two flops before any logic looks at a pin
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 3'h0;
            sync2_reg <= 3'h0;
            prev_reg <= 2'h0;
        end else begin
            sync1_reg <= {teach_btn_i, harv_release_i, harv_press_i};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg[1:0];
        end
    end

    // Rising edge of press or of release; each one counts as an actuation
    assign act = |(sync2_reg[1:0] & ~prev_reg);

    // Pending actions; a new request wins over the clearing actuation
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            pair_pend_reg <= 1'b0;
            unpair_pend_reg <= 1'b0;
        end else begin
            if (accept && req_kind_i == ncfg_pkg::NCFG_REQ_PAIR) begin
                pair_pend_reg <= 1'b1;
            end else if (act) begin
                pair_pend_reg <= 1'b0;
            end
            if (accept && req_kind_i == ncfg_pkg::NCFG_REQ_UNPAIR) begin
                unpair_pend_reg <= 1'b1;
            end else if (act) begin
                unpair_pend_reg <= 1'b0;
            end
        end
    end

    // One message per actuation; pairing beats unpairing
    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            msg_valid_reg <= 1'b0;
            msg_kind_reg <= ncfg_pkg::NCFG_MSG_DATA;
        end else begin
            msg_valid_reg <= act;
            if (act) begin
                if (sync2_reg[2] || pair_pend_reg) begin
                    msg_kind_reg <= ncfg_pkg::NCFG_MSG_PAIR;
                end else if (unpair_pend_reg) begin
                    msg_kind_reg <= ncfg_pkg::NCFG_MSG_UNPAIR;
                end else begin
                    msg_kind_reg <= ncfg_pkg::NCFG_MSG_DATA;
                end
            end
        end
    end

    assign rdata_o = rdata_reg;
    assign resp_valid_o = resp_valid_reg;
    assign resp_code_o = resp_code_reg;
    assign msg_valid_o = msg_valid_reg;
    assign msg_kind_o = msg_kind_reg;
    assign link_key_o = key_reg;
    assign live_cfg_o = live_mem[0];

    // ====================================================================
    // Assertions
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_pair_armed;
        pair_pend_reg && !act ##1 act && !req_i;
    endsequence
    sequence s_unpair_armed;
        unpair_pend_reg && !pair_pend_reg && !sync2_reg[2] && act;
    endsequence

    property p_bad_pin;
        req_i && !chk_bus.pin_ok |=> resp_valid_o && resp_code_o == ncfg_pkg::NCFG_BADPIN;
    endproperty
    a_bad_pin: assert property (p_bad_pin) else $error("wrong PIN not refused");

    property p_denied;
        req_i && req_user_i && chk_bus.pin_ok && req_kind_i != ncfg_pkg::NCFG_REQ_SETMASK
            && (req_need(req_kind_i, req_sel_i) & ~rmask_reg) != 32'h0
            |=> resp_code_o == ncfg_pkg::NCFG_DENIED;
    endproperty
    a_denied: assert property (p_denied) else $error("restricted option not denied");

    property p_no_change;
        req_i && !accept |=> $stable(live_mem[0]) && $stable(rmask_reg) && $stable(key_reg);
    endproperty
    a_no_change: assert property (p_no_change) else $error("refused request changed state");

    property p_unpair_le;
        req_i && chk_bus.pin_ok && chk_bus.perm_ok && req_kind_i == ncfg_pkg::NCFG_REQ_UNPAIR
            && !mesh |=> resp_code_o == ncfg_pkg::NCFG_BADARG ##1 !unpair_pend_reg;
    endproperty
    a_unpair_le: assert property (p_unpair_le) else $error("unpair accepted on LE");

    property p_pair_msg;
        s_pair_armed |=> msg_valid_o && msg_kind_o == ncfg_pkg::NCFG_MSG_PAIR && !pair_pend_reg;
    endproperty
    a_pair_msg: assert property (p_pair_msg) else $error("pairing message missing");

    property p_unpair_msg;
        s_unpair_armed |=> msg_kind_o == ncfg_pkg::NCFG_MSG_UNPAIR;
    endproperty
    a_unpair_msg: assert property (p_unpair_msg) else $error("unpairing message missing");

    property p_teach;
        act && sync2_reg[2] |=> msg_valid_o && msg_kind_o == ncfg_pkg::NCFG_MSG_PAIR;
    endproperty
    a_teach: assert property (p_teach) else $error("teach button ignored");

    property p_reserved;
        (rmask_reg & ~ncfg_pkg::OPT_IMPL) == 32'h0 && pmask_reg == ncfg_pkg::OPT_IMPL;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bitmap bit set");

    property p_stage_hidden;
        rd_i && addr_i >= ncfg_pkg::STAGE_LO |=> rdata_o == 32'h0;
    endproperty
    a_stage_hidden: assert property (p_stage_hidden) else $error("staging page readable");

    property p_new_key;
        accept && req_kind_i == ncfg_pkg::NCFG_REQ_FRESET |=> link_key_o == $past(lfsr_reg);
    endproperty
    a_new_key: assert property (p_new_key) else $error("link key not renewed");
endmodule
`default_nettype wire

// File: sim/ncfg_reader.sv
// Reader model: drives page accesses and requests into the block
`default_nettype none
module ncfg_reader (
    input wire logic mclk_i,
    input wire logic [31:0] rdata_i,
    input wire logic resp_valid_i,
    input wire ncfg_pkg::ncfg_resp_e resp_code_i,
    output logic [6:0] addr_o,
    output logic [31:0] wdata_o,
    output logic wr_o,
    output logic rd_o,
    output logic req_o,
    output logic user_o,
    output ncfg_pkg::ncfg_req_e kind_o,
    output logic [31:0] pin_o,
    output logic [31:0] sel_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================================================================
    // Idle state: all strobes low from time zero
    initial begin
        {addr_o, wdata_o, wr_o, rd_o, req_o, user_o, pin_o, sel_o} = '0;
        kind_o = ncfg_pkg::NCFG_REQ_UPDATE;
    end
    // One page access; read data are only valid in the cycle after the strobe
    task automatic access(input logic w, input logic [6:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        @(posedge mclk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= w;
        rd_o <= ~w;
        @(posedge mclk_i);
        wr_o <= 1'b0;
        rd_o <= 1'b0;
        #1;
        q = rdata_i;
    endtask
    // Every request carries the PIN and selection mask it is given, right or wrong
    task automatic request(input logic u, input logic [2:0] k, input logic [31:0] p,
                           input logic [31:0] s, output ncfg_pkg::ncfg_resp_e c);
        @(posedge mclk_i);
        req_o <= 1'b1;
        user_o <= u;
        kind_o <= ncfg_pkg::ncfg_req_e'(k);
        pin_o <= p;
        sel_o <= s;
        @(posedge mclk_i);
        req_o <= 1'b0;
        #1;
        // A missing answer pulse flips the code, so it never matches
        c = (resp_valid_i === 1'b1) ? resp_code_i : ncfg_pkg::ncfg_resp_e'(~resp_code_i);
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the contactless configuration block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] PP = ncfg_pkg::PPIN_RST;
    localparam logic [31:0] RP = ncfg_pkg::RPIN_RST;
    // Row: op 0 write, 1 read (e = data), 2 request (d = sel, e = live page)
    typedef struct {logic [1:0] op; logic [6:0] a; logic u; logic [2:0] k;
        logic [31:0] d; logic [31:0] p; logic [31:0] e; logic [1:0] c;} ncfg_row_s;
    // ====================================================================
    // Ordinary cases
    ncfg_row_s rows [0:22] = '{
        '{2'h1, 7'h29, 1'b0, 3'h0, 32'h0, 32'h0, 32'h00010AE0, 2'h0},
        '{2'h1, 7'h04, 1'b0, 3'h0, 32'h0, 32'h0, 32'h39324333, 2'h0},
        '{2'h1, 7'h45, 1'b0, 3'h0, 32'h0, 32'h0, 32'h000FFFFF, 2'h0},
        '{2'h1, 7'h2A, 1'b0, 3'h0, 32'h0, 32'h0, 32'h00000000, 2'h0},
        '{2'h1, 7'h7C, 1'b0, 3'h0, 32'h0, 32'h0, 32'h00000000, 2'h0},
        '{2'h0, 7'h18, 1'b0, 3'h0, 32'hA5A55A5A, 32'h0, 32'h0, 2'h0},
        '{2'h1, 7'h18, 1'b0, 3'h0, 32'h0, 32'h0, 32'hA5A55A5A, 2'h0},
        '{2'h0, 7'h00, 1'b0, 3'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 2'h0},
        '{2'h1, 7'h00, 1'b0, 3'h0, 32'h0, 32'h0, 32'h30533033, 2'h0},
        '{2'h0, 7'h2C, 1'b0, 3'h0, 32'hFFFFFFFF, 32'h0, 32'h0, 2'h0},
        '{2'h1, 7'h2C, 1'b0, 3'h0, 32'h0, 32'h0, 32'h00000000, 2'h0},
        '{2'h0, 7'h50, 1'b0, 3'h0, 32'h00000100, 32'h0, 32'h0, 2'h0},
        '{2'h1, 7'h50, 1'b0, 3'h0, 32'h0, 32'h0, 32'h00000000, 2'h0},
        '{2'h2, 7'h00, 1'b0, 3'h2, 32'h0, PP, 32'h0, 2'h2},
        '{2'h2, 7'h00, 1'b1, 3'h0, 32'h1, PP, 32'h0, 2'h3},
        '{2'h2, 7'h00, 1'b0, 3'h0, 32'h00100001, PP, 32'h0, 2'h1},
        '{2'h2, 7'h00, 1'b0, 3'h0, 32'h1, PP, 32'h100, 2'h0},
        '{2'h2, 7'h00, 1'b1, 3'h4, 32'hFFFFFFFF, RP, 32'h100, 2'h1},
        '{2'h2, 7'h00, 1'b0, 3'h4, 32'hFFFBFFFE, PP, 32'h100, 2'h0},
        '{2'h1, 7'h46, 1'b0, 3'h0, 32'h0, 32'h0, 32'h000BFFFE, 2'h0},
        '{2'h2, 7'h00, 1'b1, 3'h1, 32'h0, RP, 32'h100, 2'h1},
        '{2'h2, 7'h00, 1'b1, 3'h0, 32'h1, RP, 32'h100, 2'h1},
        '{2'h2, 7'h00, 1'b1, 3'h0, 32'h2, RP, 32'h100, 2'h0}};
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [6:0] addr;
    logic [31:0] wdata, pin, sel, rdata_o, link_key_o, live_cfg_o, q;
    logic wr, rd, req, user, resp_valid_o, msg_valid_o;
    logic teach_btn_i = 1'b0;
    logic harv_press_i = 1'b0;
    logic harv_release_i = 1'b0;
    ncfg_pkg::ncfg_req_e kind;
    ncfg_pkg::ncfg_resp_e resp_code_o, c;
    ncfg_pkg::ncfg_msg_e msg_kind_o;
    int failures = 0;
    int num_checks = 0;
    // 125 MHz clock
    always #4 mclk_i = ~mclk_i;
    ncfg_top dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata_o), .req_i(req), .req_user_i(user),
        .req_kind_i(kind), .req_pin_i(pin), .req_sel_i(sel), .resp_valid_o(resp_valid_o),
        .resp_code_o(resp_code_o), .teach_btn_i(teach_btn_i), .harv_press_i(harv_press_i),
        .harv_release_i(harv_release_i), .msg_valid_o(msg_valid_o), .msg_kind_o(msg_kind_o),
        .link_key_o(link_key_o), .live_cfg_o(live_cfg_o));
    ncfg_reader rdr (.mclk_i(mclk_i), .rdata_i(rdata_o), .resp_valid_i(resp_valid_o),
        .resp_code_i(resp_code_o), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
        .req_o(req), .user_o(user), .kind_o(kind), .pin_o(pin), .sel_o(sel));
    // ====================================================================
    // Compare and closing tasks
    task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_code(input logic [1:0] e, input ncfg_pkg::ncfg_resp_e g);
        num_checks++;
        if (g !== ncfg_pkg::ncfg_resp_e'(e)) begin
            failures++;
            $display("BAD resp_code expected %h seen %h", e, g);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // One actuation on a harvester pin; the message pulse is awaited under a bound
    task automatic actuate(input logic rel, input ncfg_pkg::ncfg_msg_e e);
        int n;
        n = 0;
        @(posedge mclk_i);
        harv_press_i <= ~rel;
        harv_release_i <= rel;
        while (n < 10 && msg_valid_o !== 1'b1) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk32("msg_valid", 32'h1, {31'h0, msg_valid_o});
        chk32("msg_kind", {30'h0, e}, {30'h0, msg_kind_o});
        @(posedge mclk_i);
        {harv_press_i, harv_release_i} <= 2'h0;
        repeat (4) @(posedge mclk_i);
    endtask
    // Watchdog: the whole run needs well under 1500 cycles
    initial begin
        repeat (3000) @(posedge mclk_i);
        failures++;
        stop_test();
    end
    // ====================================================================
    // Main sequence
    initial begin
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        chk32("link_key", ncfg_pkg::KEY_SEED, link_key_o);
        chk32("live_cfg", 32'h0, live_cfg_o);
        foreach (rows[i]) begin
            if (rows[i].op == 2'h2) begin
                rdr.request(rows[i].u, rows[i].k, rows[i].p, rows[i].d, c);
                chk_code(rows[i].c, c);
                chk32("live_cfg", rows[i].e, live_cfg_o);
            end else begin
                rdr.access(~rows[i].op[0], rows[i].a, rows[i].d, q);
                if (rows[i].op == 2'h1) chk32("rdata", rows[i].e, q);
            end
        end
        // Pairing: one message on the next actuation, then data again
        rdr.request(1'b0, 3'h1, PP, 32'h0, c);
        chk_code(2'h0, c);
        actuate(1'b0, ncfg_pkg::NCFG_MSG_PAIR);
        actuate(1'b1, ncfg_pkg::NCFG_MSG_DATA);
        teach_btn_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        actuate(1'b0, ncfg_pkg::NCFG_MSG_PAIR);
        teach_btn_i <= 1'b0;
        // Mesh protocol now live, so unpairing is accepted
        rdr.request(1'b0, 3'h2, PP, 32'h0, c);
        chk_code(2'h0, c);
        actuate(1'b1, ncfg_pkg::NCFG_MSG_UNPAIR);
        actuate(1'b0, ncfg_pkg::NCFG_MSG_DATA);
        // Restricted reset leaves the page it may not change
        rdr.request(1'b1, 3'h3, RP, 32'h0, c);
        chk_code(2'h0, c);
        chk32("live_cfg", 32'h100, live_cfg_o);
        chk32("key renewed", 32'h1, {31'h0, link_key_o !== ncfg_pkg::KEY_SEED});
        rdr.request(1'b0, 3'h3, PP, 32'h0, c);
        chk_code(2'h0, c);
        chk32("live_cfg", ncfg_pkg::LIVE_RST, live_cfg_o);
        stop_test();
    end
endmodule
`default_nettype wire
